// ==== src/sps_pkg.sv ====
// Shared constants, register map and types of the switch reset sequencer
package sps_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ      = 20;
  localparam int POR_TIME_MS  = 23;
  localparam int PIN_TIME_US  = 760;
  localparam int PHY_TIME_US  = 110;
  localparam int EMU_TIME_US  = 1;
  localparam int POR_CYCLES   = POR_TIME_MS * 1000 * CLK_MHZ;
  localparam int PIN_CYCLES   = PIN_TIME_US * CLK_MHZ;
  localparam int SEQ_W        = 20;
  localparam int XT_W         = 12;
  localparam logic [XT_W-1:0] PHY_CYCLES = XT_W'(PHY_TIME_US * CLK_MHZ);
  localparam logic [XT_W-1:0] EMU_CYCLES = XT_W'(EMU_TIME_US * CLK_MHZ);
  localparam int NUM_SM       = 3;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_PROBE     = 8'h00;
  localparam logic [7:0] OFS_HWCFG     = 8'h04;
  localparam logic [7:0] OFS_RSTCTL    = 8'h08;
  localparam logic [7:0] OFS_P1_BASIC  = 8'h0C;
  localparam logic [7:0] OFS_P2_BASIC  = 8'h10;
  localparam logic [7:0] OFS_EMU_BASIC = 8'h14;
  localparam logic [7:0] OFS_LDCMD     = 8'h18;

  // ==========================================================================
  // Field positions and values
  localparam int RC_CORE    = 0;
  localparam int RC_P1      = 1;
  localparam int BC_RESET   = 15;
  localparam int HW_READY   = 0;
  localparam int HW_LD_BUSY = 1;
  localparam int LC_RELOAD  = 0;
  localparam int LC_BUSY    = 31;
  localparam logic [31:0] PROBE_VALUE   = 32'h87654321;
  localparam logic [31:0] PROBE_INVALID = 32'h00000000;
  localparam logic [31:0] WORD_ZERO     = 32'h00000000;
  localparam logic        RESP_OKAY     = 1'h0;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_POR       = 3'b000,
    ST_PIN_HOLD  = 3'b001,
    ST_SERIAL    = 3'b010,
    ST_LOAD      = 3'b011,
    ST_LOAD_WAIT = 3'b100,
    ST_READY     = 3'b101
  } sps_state_e;

  typedef struct packed {
    logic       chip;             // Whole-device reset
    logic       core;             // All sub-modules except transceivers
    logic       serial_if;        // Serial management interfaces
    logic       keep_immune;      // Core reset: immune bits hold
    logic [1:0] xcvr;             // Transceiver logic reset
    logic [1:0] xcvr_reg;         // Transceiver register reset
    logic [1:0] xcvr_keep_immune; // Transceiver immune bits hold
    logic       emu;              // Emulated transceiver reset
  } sps_resets_s;

  typedef struct packed {
    sps_state_e         state;
    logic               chip;
    logic               ld_busy;
    logic               dp_write;
    logic [7:0]         dp_addr;
    logic [31:0]        hrdata;
    logic [NUM_SM-1:0]  src_basic;
    logic [NUM_SM-1:0]  src_pd;
    logic [1:0]         pd_q;
  } sps_main_s;

endpackage : sps_pkg

// ==== src/sps_reset_seq.sv ====
// Reset sequencer of a three-port switch with its AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module sps_reset_seq #(
  parameter int POR_CYC = sps_pkg::POR_CYCLES,
  parameter int PIN_CYC = sps_pkg::PIN_CYCLES,
  parameter int STRAP_W = 8
) (
  input  wire logic               hclk,                  // Clock, 20 MHz
  input  wire logic               hresetn,               // Power-on reset
  input  wire logic               hsel,                  // Slave select
  input  wire logic [31:0]        haddr,                 // Byte address
  input  wire logic [1:0]         htrans,                // Transfer type
  input  wire logic               hwrite,                // Write access
  input  wire logic [2:0]         hsize,                 // Word only
  input  wire logic [31:0]        hwdata,                // Write data
  input  wire logic               hready,                // Bus ready
  output logic                    hreadyout,             // Never waits
  output logic                    hresp,                 // Always OKAY
  output logic [31:0]             hrdata,                // Read data
  input  wire logic               external_reset_pin_n,  // Reset pin
  input  wire logic [1:0]         transceiver_powerdown, // Power-down
  input  wire logic               eeprom_present,        // EEPROM valid
  input  wire logic               loader_done,           // Loader end
  input  wire logic               loader_strap_we,       // Override
  input  wire logic [STRAP_W-1:0] loader_strap_data,     // Override data
  input  wire logic [STRAP_W-1:0] strap_pins,            // Strap pins
  output logic                    loader_start,          // Run loader
  output logic [STRAP_W-1:0]      strap_value,           // Straps in use
  output sps_pkg::sps_resets_s    resets,                // Reset scopes
  output logic                    device_ready           // Ready flag
);

  sps_pkg::sps_main_s r;
  sps_pkg::sps_main_s next_r;

  logic                       seq_start;
  logic [sps_pkg::SEQ_W-1:0]  seq_load;
  logic                       seq_busy;
  logic                       strap_latch;
  logic                       strap_revert;
  logic                       addr_acc;
  logic                       wr_ok;
  logic                       core_act;
  logic                       ready;
  logic [31:0]                rd_word;
  logic [sps_pkg::NUM_SM-1:0] sm_req;
  logic [sps_pkg::NUM_SM-1:0] sm_basic;
  logic [sps_pkg::NUM_SM-1:0] sm_busy;
  logic [sps_pkg::NUM_SM-1:0] pd_fall;

  // ==========================================================================
  // Decoding
  function automatic logic [7:0] basic_ofs(input int idx);
    if (idx == 0)
      return sps_pkg::OFS_P1_BASIC;
    else if (idx == 1)
      return sps_pkg::OFS_P2_BASIC;
    else
      return sps_pkg::OFS_EMU_BASIC;
  endfunction : basic_ofs

  function automatic logic [sps_pkg::XT_W-1:0] sm_cycles(input int idx);
    if (idx < 2)
      return sps_pkg::PHY_CYCLES;
    else
      return sps_pkg::EMU_CYCLES;
  endfunction : sm_cycles

  assign ready    = (r.state == sps_pkg::ST_READY);
  assign core_act = (r.state == sps_pkg::ST_POR) ||
                    (r.state == sps_pkg::ST_PIN_HOLD) ||
                    (r.state == sps_pkg::ST_SERIAL);
  assign addr_acc = hsel && hready && htrans[1];
  // Writes before ready are dropped without an error answer
  assign wr_ok    = r.dp_write && ready;
  assign pd_fall  = {1'b0, r.pd_q & ~transceiver_powerdown};

  // ==========================================================================
  // Read data, captured in the address phase
  always_comb
  begin
    rd_word = sps_pkg::WORD_ZERO;
    if (haddr[7:0] == sps_pkg::OFS_PROBE)
      rd_word = core_act ? sps_pkg::PROBE_INVALID
                         : sps_pkg::PROBE_VALUE;
    else if (haddr[7:0] == sps_pkg::OFS_HWCFG)
    begin
      rd_word[sps_pkg::HW_READY]   = ready;
      rd_word[sps_pkg::HW_LD_BUSY] = r.ld_busy;
    end
    else if (haddr[7:0] == sps_pkg::OFS_RSTCTL)
      rd_word[sps_pkg::RC_P1 +: sps_pkg::NUM_SM] = sm_busy;
    else if (!ready)
      rd_word = sps_pkg::WORD_ZERO;
    else if (haddr[7:0] == sps_pkg::OFS_P1_BASIC)
      rd_word[sps_pkg::BC_RESET] = sm_busy[0];
    else if (haddr[7:0] == sps_pkg::OFS_P2_BASIC)
      rd_word[sps_pkg::BC_RESET] = sm_busy[1];
    else if (haddr[7:0] == sps_pkg::OFS_EMU_BASIC)
      rd_word[sps_pkg::BC_RESET] = sm_busy[2];
    else if (haddr[7:0] == sps_pkg::OFS_LDCMD)
      rd_word[sps_pkg::LC_BUSY] = r.ld_busy;
  end

  // ==========================================================================
  // Single-module requests
  always_comb
  begin
    for (int i = 0; i < sps_pkg::NUM_SM; i++)
    begin
      sm_basic[i] = wr_ok && (r.dp_addr == basic_ofs(i)) &&
                    hwdata[sps_pkg::BC_RESET];
      sm_req[i]   = sm_basic[i] || pd_fall[i] ||
                    (wr_ok && (r.dp_addr == sps_pkg::OFS_RSTCTL) &&
                     hwdata[sps_pkg::RC_P1 + i]);
    end
  end

  // ==========================================================================
  // Sequencer
  always_comb
  begin
    next_r       = r;
    seq_start    = 1'b0;
    seq_load     = '0;
    strap_latch  = 1'b0;
    strap_revert = 1'b0;
    loader_start = 1'b0;
    next_r.pd_q  = transceiver_powerdown;

    if (addr_acc)
    begin
      next_r.dp_write = hwrite;
      next_r.dp_addr  = haddr[7:0];
      if (!hwrite)
        next_r.hrdata = rd_word;
    end
    else
      next_r.dp_write = 1'b0;

    for (int i = 0; i < sps_pkg::NUM_SM; i++)
    begin
      if (sm_req[i])
      begin
        next_r.src_basic[i] = sm_basic[i];
        next_r.src_pd[i]    = pd_fall[i];
      end
    end

    // Clear before set so a start in the done cycle is kept
    if (loader_done)
      next_r.ld_busy = 1'b0;

    case (r.state)
      sps_pkg::ST_POR:
      begin
        seq_start    = 1'b1;
        seq_load     = sps_pkg::SEQ_W'(POR_CYC);
        strap_latch  = 1'b1;
        next_r.state = sps_pkg::ST_SERIAL;
      end
      sps_pkg::ST_PIN_HOLD:
      begin
        if (external_reset_pin_n)
        begin
          seq_start    = 1'b1;
          seq_load     = sps_pkg::SEQ_W'(PIN_CYC);
          strap_latch  = 1'b1;
          next_r.state = sps_pkg::ST_SERIAL;
        end
      end
      sps_pkg::ST_SERIAL:
      begin
        if (!seq_busy)
          next_r.state = sps_pkg::ST_LOAD;
      end
      sps_pkg::ST_LOAD:
      begin
        loader_start   = 1'b1;
        next_r.ld_busy = 1'b1;
        next_r.state   = sps_pkg::ST_LOAD_WAIT;
      end
      sps_pkg::ST_LOAD_WAIT:
      begin
        if (loader_done)
        begin
          next_r.chip  = 1'b0;
          next_r.state = sps_pkg::ST_READY;
        end
      end
      sps_pkg::ST_READY:
      begin
        if (wr_ok && (r.dp_addr == sps_pkg::OFS_RSTCTL) &&
            hwdata[sps_pkg::RC_CORE])
        begin
          seq_start    = 1'b1;
          seq_load     = sps_pkg::SEQ_W'(PIN_CYC);
          strap_revert = !eeprom_present;
          next_r.state = sps_pkg::ST_SERIAL;
        end
        else if (wr_ok && (r.dp_addr == sps_pkg::OFS_LDCMD) &&
                 hwdata[sps_pkg::LC_RELOAD] && !r.ld_busy)
        begin
          loader_start   = 1'b1;
          next_r.ld_busy = 1'b1;
          strap_revert   = !eeprom_present;
        end
      end
      default:
        next_r.state = sps_pkg::ST_POR;
    endcase

    // The pin overrides the state and chip flag set by every other step
    if (!external_reset_pin_n)
    begin
      next_r.chip  = 1'b1;
      next_r.state = sps_pkg::ST_PIN_HOLD;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r       <= '0;
      r.state <= sps_pkg::ST_POR;
      r.chip  <= 1'b1;
    end
    else
      r <= next_r;
  end

  // ==========================================================================
  // Reset outputs
  always_comb
  begin
    resets.chip        = r.chip && core_act;
    resets.core        = core_act;
    resets.serial_if   = core_act;
    resets.keep_immune = core_act && !r.chip;
    for (int i = 0; i < 2; i++)
    begin
      resets.xcvr[i]     = resets.chip || sm_busy[i];
      resets.xcvr_reg[i] = resets.chip ||
                           (sm_busy[i] && !r.src_pd[i]);
      resets.xcvr_keep_immune[i] = !resets.chip && sm_busy[i] &&
                                   r.src_basic[i];
    end
    resets.emu = resets.chip || sm_busy[2];
  end

  assign device_ready = ready;
  assign hreadyout    = 1'b1;
  assign hresp        = sps_pkg::RESP_OKAY;
  assign hrdata       = r.hrdata;

  // ==========================================================================
  // Timers and straps
  sps_timer #(
    .W (sps_pkg::SEQ_W)
  ) u_seq_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (seq_start),
    .load    (seq_load),
    .busy    (seq_busy)
  );

  genvar g;
  generate
    for (g = 0; g < sps_pkg::NUM_SM; g++)
    begin : g_sm
      sps_timer #(
        .W (sps_pkg::XT_W)
      ) u_sm_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (sm_req[g]),
        .load    (sm_cycles(g)),
        .busy    (sm_busy[g])
      );
    end
  endgenerate

  sps_strap_store #(
    .W (STRAP_W)
  ) u_straps (
    .hclk    (hclk),
    .hresetn (hresetn),
    .latch   (strap_latch),
    .pins    (strap_pins),
    .revert  (strap_revert),
    .ld_we   (loader_strap_we),
    .ld_data (loader_strap_data),
    .value   (strap_value)
  );

  // ==========================================================================
  // Checks
  a_chip_all_resets: assert property (
    @(posedge hclk) disable iff (!hresetn)
    resets.chip |-> (resets.core && resets.serial_if &&
                     (resets.xcvr == 2'h3) && resets.emu))
    else $error("chip reset does not cover every scope");

  a_loader_after_base: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (r.state == sps_pkg::ST_SERIAL && !seq_busy &&
     external_reset_pin_n) |=> loader_start)
    else $error("loader not started after base interval");

  a_probe_invalid: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_acc && !hwrite && haddr[7:0] == sps_pkg::OFS_PROBE &&
     core_act) |=> (hrdata == sps_pkg::PROBE_INVALID))
    else $error("probe readable during serial reset");

  a_ready_after_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(device_ready) |-> $past(loader_done))
    else $error("ready set without loader end");

  a_ready_low_reset: assert property (
    @(posedge hclk) disable iff (!hresetn)
    resets.core |-> !device_ready)
    else $error("ready high during reset");

  a_early_write_drop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (r.dp_write && !ready && !sm_busy[0] && !pd_fall[0]) |=> !sm_busy[0])
    else $error("write honoured before ready");

  a_core_spares_phy: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (resets.core && !r.chip && !sm_busy[0]) |-> !resets.xcvr[0])
    else $error("core reset reached a transceiver");

  a_emu_self_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ($rose(sm_busy[2]) && !sm_req[2]) |-> ##19 (sm_busy[2] || sm_req[2])
      ##1 (!sm_busy[2] || $past(sm_req[2])))
    else $error("emulated reset bit timing wrong");

  a_pd_keeps_regs: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (sm_busy[0] && r.src_pd[0] && !resets.chip) |-> !resets.xcvr_reg[0])
    else $error("power-down reset cleared registers");

endmodule : sps_reset_seq
`default_nettype wire

// ==== src/sps_strap_store.sv ====
// Latched configuration straps with loader override
`timescale 1ns/1ps
`default_nettype none
module sps_strap_store #(
  parameter int W = 8
) (
  input  wire logic         hclk,     // System clock
  input  wire logic         hresetn,  // Async reset, active low
  input  wire logic         latch,    // Sample the strap pins
  input  wire logic [W-1:0] pins,     // Strap pin levels
  input  wire logic         revert,   // Back to last latched values
  input  wire logic         ld_we,    // Loader override strobe
  input  wire logic [W-1:0] ld_data,  // Loader override value
  output logic      [W-1:0] value     // Strap value in use
);

  typedef struct packed {
    logic [W-1:0] latched;
    logic [W-1:0] value;
  } sps_strap_s;

  sps_strap_s r;
  sps_strap_s next_r;

  // ==========================================================================
  // Pins are sampled by a clocked step after the release, never in reset
  always_comb
  begin
    next_r = r;
    if (latch)
    begin
      next_r.latched = pins;
      next_r.value   = pins;
    end
    else if (ld_we)
      next_r.value = ld_data;
    else if (revert)
      next_r.value = r.latched;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign value = r.value;

endmodule : sps_strap_store
`default_nettype wire

// ==== src/sps_timer.sv ====
// Down-counter that runs one reset interval
`timescale 1ns/1ps
`default_nettype none
module sps_timer #(
  parameter int W = 12
) (
  input  wire logic         hclk,    // System clock
  input  wire logic         hresetn, // Async reset, active low
  input  wire logic         start,   // Load and start
  input  wire logic [W-1:0] load,    // Interval in cycles
  output logic              busy     // Interval running
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } sps_tmr_s;

  sps_tmr_s r;
  sps_tmr_s next_r;

  // ==========================================================================
  // Counter
  always_comb
  begin
    next_r = r;
    if (start)
      next_r.cnt = load;
    else if (r.cnt != '0)
      next_r.cnt = r.cnt - W'(1);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign busy = (r.cnt != '0);

endmodule : sps_timer
`default_nettype wire

// ==== tb/sps_loader_model.sv ====
// Behavioural configuration loader facing the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module sps_loader_model #(
  parameter int DLY = 40
) (
  input  wire logic       hclk,       // System clock
  input  wire logic       start,      // Load request pulse
  input  wire logic       present,    // EEPROM fitted
  input  wire logic [7:0] img,        // Strap image in the EEPROM
  output logic            done,       // Load finished pulse
  output logic            strap_we,   // Strap override pulse
  output logic [7:0]      strap_data  // Strap override value
);
  // ==========================================================================
  // Load sequence
  initial
  begin
    done       = 1'b0;
    strap_we   = 1'b0;
    strap_data = 8'h00;
    forever
    begin
      @(posedge hclk);
      if (start === 1'b1)
      begin
        repeat (DLY) @(posedge hclk);
        if (present === 1'b1)
        begin
          strap_we   <= 1'b1;
          strap_data <= img;
          @(posedge hclk);
          strap_we   <= 1'b0;
          // Released data must not look like a held value
          strap_data <= ~img;
        end
        done <= 1'b1;
        @(posedge hclk);
        done <= 1'b0;
      end
    end
  end
endmodule : sps_loader_model
`default_nettype wire

// ==== tb/sps_reset_seq_tb_top.sv ====
// Self-checking bench of the switch reset sequencer
`timescale 1ns/1ps
`default_nettype none
module sps_reset_seq_tb_top;
  localparam int POR = 50;
  localparam int PIN = 30;
  localparam int PHY = int'(sps_pkg::PHY_CYCLES);
  localparam int EMU = int'(sps_pkg::EMU_CYCLES);
  logic                 hclk = 1'b0;
  logic                 hresetn = 1'b0;
  logic                 hsel = 1'b0;
  logic [31:0]          haddr = 32'h00000000;
  logic [1:0]           htrans = 2'h0;
  logic                 hwrite = 1'b0;
  logic [31:0]          hwdata = 32'h00000000;
  logic                 hreadyout;
  logic                 hresp;
  logic [31:0]          hrdata;
  logic                 pin_n = 1'b1;
  logic [1:0]           pdown = 2'h0;
  logic                 present = 1'b1;
  logic                 ld_done;
  logic                 ld_we;
  logic [7:0]           ld_data;
  logic [7:0]           pins = 8'h00;
  logic [7:0]           img = 8'h00;
  logic                 loader_start;
  logic [7:0]           strap_value;
  sps_pkg::sps_resets_s resets;
  logic                 device_ready;
  logic                 rd_chk = 1'b0;
  logic [31:0]          exp_q[$];
  logic [31:0]          exp_w;
  logic [31:0]          lfsr = 32'h00000496;
  logic [7:0]           pins_a;
  int                   n_fail = 0;
  int                   comparisons = 0;
  int                   n_ld = 0;

  always #25 hclk = ~hclk;

  sps_reset_seq #(.POR_CYC(POR), .PIN_CYC(PIN), .STRAP_W(8)) i_sps_reset_seq (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .external_reset_pin_n(pin_n),
    .transceiver_powerdown(pdown), .eeprom_present(present),
    .loader_done(ld_done), .loader_strap_we(ld_we),
    .loader_strap_data(ld_data), .strap_pins(pins),
    .loader_start(loader_start), .strap_value(strap_value),
    .resets(resets), .device_ready(device_ready));

  sps_loader_model i_sps_loader_model (
    .hclk(hclk), .start(loader_start), .present(present), .img(img),
    .done(ld_done), .strap_we(ld_we), .strap_data(ld_data));

  // ==========================================================================
  // Checking
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic s);
    chk_word(nm, {31'h0, e}, {31'h0, s});
  endtask : chk_bit

  task automatic bound(input logic ok);
    if (!ok)
    begin
      n_fail++;
      $display("ERROR wait ran out");
      summarize();
    end
  endtask : bound

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  function automatic logic pick(input int w);
    return (w == 2) ? resets.emu : resets.xcvr[w[0]];
  endfunction : pick

  always @(posedge hclk)
  begin
    if (loader_start === 1'b1)
      n_ld++;
    if (rd_chk === 1'b1 && hreadyout === 1'b1)
    begin
      exp_w = exp_q.pop_front();
      chk_word("hrdata", exp_w, hrdata);
      chk_bit("hresp", sps_pkg::RESP_OKAY, hresp);
    end
  end

  // ==========================================================================
  // Bus master
  task automatic hwait();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    bound(n < 64);
  endtask : hwait

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic c,
                      input logic [31:0] e, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    hwait();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_chk <= c;
    if (c)
      exp_q.push_back(e);
    hwait();
    q = hrdata;
    rd_chk <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, 1'b0, 32'h0, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, 1'b1, e, q);
  endtask : rd

  // Host polls only probe and config while not ready
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    logic [31:0] q;
    int          n;
    n = 0;
    do
    begin
      xfer(1'b0, a, 32'h0, 1'b0, 32'h0, q);
      n++;
    end
    while ((q & m) !== m && n < 400);
    bound(n < 400);
  endtask : poll

  // Cycles until the loader is asked to run
  task automatic ld_gap(input int lo, input int hi);
    int n;
    n = 0;
    while (loader_start !== 1'b1 && n < hi + 8)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk_bit("load gap", 1'b1, n >= lo && n <= hi);
  endtask : ld_gap

  // ==========================================================================
  // Single-module reset: trigger, scope, length, self-clear
  task automatic one(input logic [7:0] ta, input logic [31:0] td,
                     input logic [7:0] sa, input logic [31:0] sm,
                     input int w, input int len, input logic ki);
    int n;
    int l0;
    l0 = n_ld;
    if (ta == 8'hFF)
    begin
      pdown[w[0]] <= 1'b1;
      @(posedge hclk);
      pdown[w[0]] <= 1'b0;
    end
    else
      wr(ta, td);
    n = 0;
    #1;
    while (pick(w) !== 1'b1 && n < 8)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    bound(n < 8);
    chk_bit("core", 1'b0, resets.core);
    chk_bit("ready", 1'b1, device_ready);
    for (int k = 0; k < 3; k++)
      if (k != w)
        chk_bit("other scope", 1'b0, pick(k));
    if (w < 2)
    begin
      chk_bit("immune", ki, resets.xcvr_keep_immune[w[0]]);
      chk_bit("xcvr reg", ta != 8'hFF, resets.xcvr_reg[w[0]]);
    end
    n = 0;
    if (sm != 32'h0)
    begin
      rd(sa, sm);
      #1;
      n = 2;
    end
    while (pick(w) === 1'b1 && n < len + 50)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk_word("reset length", len, n);
    if (sm != 32'h0)
      rd(sa, 32'h0);
    chk_word("loader runs", l0, n_ld);
    $display("single reset %0d done", w);
  endtask : one

  // ==========================================================================
  // Main sequence
  initial
  begin
    pins_a = 8'(rnd());
    pins   <= pins_a;
    img    <= 8'(rnd());
    @(posedge hclk);
    #1;
    chk_bit("chip in reset", 1'b1, resets.chip);
    chk_bit("ready in reset", 1'b0, device_ready);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(sps_pkg::OFS_PROBE, sps_pkg::PROBE_INVALID);
    poll(sps_pkg::OFS_PROBE, sps_pkg::PROBE_VALUE);
    wr(sps_pkg::OFS_RSTCTL, 32'h1 << sps_pkg::RC_P1);
    repeat (2) @(posedge hclk);
    #1;
    chk_bit("early write", 1'b0, resets.xcvr[0]);
    rd(sps_pkg::OFS_RSTCTL, 32'h0);
    rd(sps_pkg::OFS_HWCFG, 32'h2);
    poll(sps_pkg::OFS_HWCFG, 32'h1);
    chk_word("straps", {24'h0, img}, {24'h0, strap_value});
    chk_word("loader runs", 1, n_ld);
    rd(8'h40, 32'h0);
    wr(8'h40, rnd());
    rd(8'h40, 32'h0);
    $display("power-on test done");
    one(sps_pkg::OFS_RSTCTL, 32'h2, sps_pkg::OFS_P1_BASIC, 32'h8000,
        0, PHY, 1'b0);
    one(sps_pkg::OFS_P2_BASIC, 32'h8000, sps_pkg::OFS_RSTCTL, 32'h4,
        1, PHY, 1'b1);
    one(sps_pkg::OFS_EMU_BASIC, 32'h8000, sps_pkg::OFS_RSTCTL, 32'h8,
        2, EMU, 1'b0);
    one(8'hFF, 32'h0, 8'h00, 32'h0, 0, PHY, 1'b0);
    present <= 1'b0;
    pins    <= ~pins_a;
    wr(sps_pkg::OFS_RSTCTL, 32'h1 << sps_pkg::RC_CORE);
    @(posedge hclk);
    #1;
    chk_bit("core", 1'b1, resets.core);
    chk_bit("chip", 1'b0, resets.chip);
    chk_bit("immune", 1'b1, resets.keep_immune);
    chk_bit("serial if", 1'b1, resets.serial_if);
    chk_word("xcvr", 32'h0, {30'h0, resets.xcvr});
    chk_bit("ready", 1'b0, device_ready);
    ld_gap(PIN - 2, PIN + 4);
    poll(sps_pkg::OFS_PROBE, sps_pkg::PROBE_VALUE);
    poll(sps_pkg::OFS_HWCFG, 32'h1);
    chk_word("straps", {24'h0, pins_a}, {24'h0, strap_value});
    chk_word("loader runs", 2, n_ld);
    $display("core reset test done");
    wr(sps_pkg::OFS_LDCMD, 32'h1 << sps_pkg::LC_RELOAD);
    rd(sps_pkg::OFS_LDCMD, 32'h1 << sps_pkg::LC_BUSY);
    chk_bit("ready", 1'b1, device_ready);
    repeat (50) @(posedge hclk);
    rd(sps_pkg::OFS_LDCMD, 32'h0);
    chk_word("straps", {24'h0, pins_a}, {24'h0, strap_value});
    chk_word("loader runs", 3, n_ld);
    $display("reload test done");
    pin_n <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    chk_bit("chip", 1'b1, resets.chip);
    chk_bit("ready", 1'b0, device_ready);
    @(posedge hclk);
    pin_n <= 1'b1;
    ld_gap(PIN - 2, PIN + 4);
    poll(sps_pkg::OFS_HWCFG, 32'h1);
    chk_word("straps", {24'h0, ~pins_a}, {24'h0, strap_value});
    chk_word("loader runs", 4, n_ld);
    $display("pin reset test done");
    summarize();
  end

  initial
  begin
    repeat (60000) @(posedge hclk);
    bound(1'b0);
  end
endmodule : sps_reset_seq_tb_top
`default_nettype wire
